// ### rtl/dpfc_pkg.sv
// Purpose: Constants shared by the DAC power, fault and configuration control block.
// Assumes: 32-bit command word framing, MSB first, sampled on the serial clock rising edge.
// Notes:   Command codes sit in the top byte of each frame.
package dpfc_pkg;
  localparam int          NCHAN            = 8;
  localparam int          FRAME_W          = 32;
  localparam int          SHORT_FRAME      = 24;
  localparam int          CRC_W            = 6;
  localparam int          CNT_W            = 7;
  localparam logic [7:0]  CMD_WR_CONFIG    = 8'h70;
  localparam logic [7:0]  CMD_WR_POWER     = 8'h71;
  localparam logic [7:0]  CMD_WR_FAULT     = 8'h76;
  localparam logic [7:0]  CMD_RD_CONFIG    = 8'hF0;
  localparam logic [7:0]  CMD_RD_POWER     = 8'hF1;
  localparam logic [7:0]  CMD_RD_FAULT     = 8'hF6;
  localparam logic [7:0]  CMD_RD_THERMAL   = 8'hF7;
  localparam logic [3:0]  CMD_UPDATE_HI    = 4'h6;
  localparam logic [7:0]  CMD_NOP          = 8'hFF;
  localparam logic [7:0]  PWR_RESET        = 8'h00;
  localparam logic [2:0]  FAULT_RESET      = 3'h0;
  localparam logic [2:0]  CFG_RESET        = 3'h0;
  localparam int          RST_BIT_POS      = 23;
  localparam int          CFG_TSD_POS      = 2;
  localparam int          CFG_EXT_POS      = 1;
  localparam int          CFG_CRC_POS      = 0;
  localparam int          FLT_TSF_POS      = 2;
  localparam int          FLT_CKF_POS      = 1;
  localparam int          FLT_CF_POS       = 0;
  localparam logic [5:0]  CRC_POLY         = 6'h03;
  typedef enum logic [1:0] {DPFC_IDLE, DPFC_SHIFT, DPFC_CLOSE} dpfc_state_t;
endpackage

// ### rtl/dpfc_sync.sv
// Purpose: Two-flip-flop synchroniser with a set value after reset.
// Assumes: Input is asynchronous to CLK.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ns
module dpfc_sync
#(
  parameter logic INIT = 1'b1
)
(
  input  wire logic CLK,
  input  wire logic SRST,
  input  wire logic D,
  output logic      Q
);
  logic meta_q;

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      meta_q <= INIT;
      Q      <= INIT;
    end
    else
    begin
      meta_q <= D;
      Q      <= meta_q;
    end
  end
endmodule

// ### rtl/dpfc_ctrl.sv
// Purpose: Control logic of an eight-channel DAC: power-down, async load, fault flags, configuration.
// Assumes: Serial pins and async pins are asynchronous to CLK and sampled at 20 MHz.
// Notes:   Serial clock must run well below CLK/4 so each edge is seen.
// How it works
// - Eight power-down bits, one per channel, one means down, cleared at reset.
// - Power-down write carries channel bits in bytes one and two, even positions.
// - Updating a channel also powers that channel up.
// - Software reset or clear pulse powers up every channel.
// - Power-down readback shows the live power state.
// - All channels down puts the device to sleep, reference and bias off.
// - Registers keep their contents during power-down and sleep.
// - Sleep ends on power-up write, update, load low, clear or soft reset.
// - Power-down read shifts out its bits during the next frame.
// - Load low while select high copies input registers to DAC registers.
// - Load low in frame powers up; still low at close executes and updates.
// - Load low at frame close blocks that frame's power-down request.
// - Over-temperature sets thermal flag and protection unless disabled.
// - Clock counts not a multiple of 32 set the clock fault, 24 allowed.
// - Failed frame check with checking on sets the command fault.
// - Fault flags hold until fault write, clear, soft reset or power cycle.
// - Any fault pulls the open-drain fault pin low until next select rise.
// - Fault write and read use the three low bits of byte two.
// - Configuration write: reset bit first in byte one, three flags in byte two.
// - Writing the reset bit performs a soft reset and it reads back zero.
// - Thermal disable inhibits shutdown, external reference stops charging; both reset zero.
// - Frame check is a six-bit code after the first 26 bits of long frames.
// - Configuration and fault commands are never frame checked.
// - A channel in thermal shutdown is set in power-down and thermal status.
`timescale 1ns/1ns
module dpfc_ctrl
(
  input  wire logic       CLK,
  input  wire logic       SRST,
  input  wire logic       SCK,
  input  wire logic       SDI,
  input  wire logic       SELECT_LOAD_N,
  input  wire logic       ASYNC_LOAD_N,
  input  wire logic       ASYNC_CLEAR_N,
  input  wire logic [7:0] CHAN_OVERTEMP,
  output logic            SDO,
  output logic            SDO_OE_N,
  output logic            FAULT_O,
  output logic            FAULT_OE_N,
  output logic [7:0]      CHAN_SLEEP_BIT,
  output logic            DEVICE_SLEEP,
  output logic [7:0]      DAC_LOAD,
  output logic            EXTERNAL_VREF_SELECT,
  output logic            VREF_COMP_CHARGE_EN
);
  logic                   sck_s;
  logic                   sel_s;
  logic                   async_load_n_s;
  logic                   clr_s;
  logic                   sdi_s;
  logic                   sck_prev_q;
  logic                   sel_prev_q;
  logic                   clr_prev_q;
  logic                   async_load_n_prev_q;
  dpfc_pkg::dpfc_state_t  state_q;
  dpfc_pkg::dpfc_state_t  state_d;
  logic [31:0]            shift_q;
  logic [dpfc_pkg::CNT_W-1:0] count_q;
  logic [7:0]             pd_q;
  logic [7:0]             tsd_q;
  logic [2:0]             fault_q;
  logic [2:0]             cfg_q;
  logic                   fault_pin_q;
  logic [31:0]            tx_q;
  logic [7:0]             next_read_q;
  logic [5:0]             crc_q;
  logic                   crc_pend_q;

  dpfc_sync #(.INIT(1'b0)) u_sck  (.CLK(CLK), .SRST(SRST), .D(SCK),           .Q(sck_s));
  dpfc_sync #(.INIT(1'b1)) u_sel  (.CLK(CLK), .SRST(SRST), .D(SELECT_LOAD_N), .Q(sel_s));
  dpfc_sync #(.INIT(1'b1)) u_async_load_n (.CLK(CLK), .SRST(SRST), .D(ASYNC_LOAD_N),  .Q(async_load_n_s));
  dpfc_sync #(.INIT(1'b1)) u_clr  (.CLK(CLK), .SRST(SRST), .D(ASYNC_CLEAR_N), .Q(clr_s));
  dpfc_sync #(.INIT(1'b0)) u_sdi  (.CLK(CLK), .SRST(SRST), .D(SDI),           .Q(sdi_s));

  wire sck_rise  = sck_s & ~sck_prev_q;
  wire sck_fall  = ~sck_s & sck_prev_q;
  wire sel_fall  = ~sel_s & sel_prev_q;
  wire sel_rise  = sel_s & ~sel_prev_q;
  wire clr_fall  = ~clr_s & clr_prev_q;
  wire async_load_n_fall = ~async_load_n_s & async_load_n_prev_q;

  // Frame close: 24-bit frames land their command in the low three bytes of the shift register.
  wire        is_short   = (count_q == dpfc_pkg::CNT_W'(dpfc_pkg::SHORT_FRAME));
  wire        cnt_ok     = is_short || (count_q[4:0] == 5'h00 && count_q != '0);
  wire [31:0] word       = is_short ? {shift_q[23:0], 8'h00} : shift_q;
  wire [7:0]  cmd        = word[31:24];
  wire [7:0]  byte1      = word[23:16];
  wire [7:0]  byte2      = word[15:8];
  wire [7:0]  pd_field   = {byte1[6], byte1[4], byte1[2], byte1[0],
                            byte2[6], byte2[4], byte2[2], byte2[0]};
  wire        is_cfg_flt = (cmd == dpfc_pkg::CMD_WR_CONFIG) || (cmd == dpfc_pkg::CMD_RD_CONFIG) ||
                           (cmd == dpfc_pkg::CMD_WR_FAULT)  || (cmd == dpfc_pkg::CMD_RD_FAULT);
  wire        crc_active = cfg_q[dpfc_pkg::CFG_CRC_POS] && !is_short && !is_cfg_flt;
  wire        crc_bad    = crc_active && (crc_q != word[5:0]);
  wire        valid      = sel_rise && cnt_ok && !crc_bad && state_q == dpfc_pkg::DPFC_SHIFT;
  wire        do_cfg     = valid && cmd == dpfc_pkg::CMD_WR_CONFIG;
  wire        soft_rst   = do_cfg && word[dpfc_pkg::RST_BIT_POS];
  wire        do_pd      = valid && cmd == dpfc_pkg::CMD_WR_POWER;
  wire        do_flt     = valid && cmd == dpfc_pkg::CMD_WR_FAULT;
  wire        do_upd     = valid && cmd[7:4] == dpfc_pkg::CMD_UPDATE_HI;
  wire [7:0]  upd_mask   = do_upd ? (8'h01 << cmd[2:0]) : 8'h00;
  wire        async_load_n_low   = ~async_load_n_s;
  wire        async_load_n_at_close = sel_rise && async_load_n_low;
  wire [7:0]  thermal_hit = cfg_q[dpfc_pkg::CFG_TSD_POS] ? 8'h00 : CHAN_OVERTEMP;
  wire        tsf_ev     = |thermal_hit;
  wire        ckf_ev     = sel_rise && state_q == dpfc_pkg::DPFC_SHIFT && !cnt_ok;
  wire        cf_ev      = sel_rise && state_q == dpfc_pkg::DPFC_SHIFT && cnt_ok && crc_bad;
  wire        clear_all  = clr_fall || soft_rst;
  wire        wake_all   = clear_all || async_load_n_fall;

  // Power-down write: a request in a frame closed with the load pin low is dropped.
  wire [7:0]  pd_write   = (do_pd && !async_load_n_at_close) ? pd_field : pd_q;
  wire [7:0]  pd_next    = wake_all ? dpfc_pkg::PWR_RESET : ((pd_write & ~upd_mask) | thermal_hit);
  wire [2:0]  flt_set;
  assign flt_set[dpfc_pkg::FLT_TSF_POS] = tsf_ev;
  assign flt_set[dpfc_pkg::FLT_CKF_POS] = ckf_ev;
  assign flt_set[dpfc_pkg::FLT_CF_POS]  = cf_ev;
  // Set wins over clear for every flag.
  wire [2:0]  flt_base   = clear_all ? dpfc_pkg::FAULT_RESET : (do_flt ? byte2[2:0] : fault_q);
  wire [7:0]  read_sel   = (cmd == dpfc_pkg::CMD_RD_POWER)   ? 8'd1 :
                           (cmd == dpfc_pkg::CMD_RD_FAULT)   ? 8'd2 :
                           (cmd == dpfc_pkg::CMD_RD_CONFIG)  ? 8'd3 :
                           (cmd == dpfc_pkg::CMD_RD_THERMAL) ? 8'd4 : 8'd0;
  wire [7:0]  pd_spread1 = {1'b0, pd_q[7], 1'b0, pd_q[6], 1'b0, pd_q[5], 1'b0, pd_q[4]};
  wire [7:0]  pd_spread2 = {1'b0, pd_q[3], 1'b0, pd_q[2], 1'b0, pd_q[1], 1'b0, pd_q[0]};
  wire [7:0]  ts_spread1 = {1'b0, tsd_q[7], 1'b0, tsd_q[6], 1'b0, tsd_q[5], 1'b0, tsd_q[4]};
  wire [7:0]  ts_spread2 = {1'b0, tsd_q[3], 1'b0, tsd_q[2], 1'b0, tsd_q[1], 1'b0, tsd_q[0]};
  // Readback is loaded at the select fall so it shows the live state then.
  wire [31:0] tx_load    = (next_read_q == 8'd1) ? {dpfc_pkg::CMD_RD_POWER, pd_spread1, pd_spread2, 8'h00} :
                           (next_read_q == 8'd2) ? {dpfc_pkg::CMD_RD_FAULT, 13'h0000, fault_q, 8'h00} :
                           (next_read_q == 8'd3) ? {dpfc_pkg::CMD_RD_CONFIG, 13'h0000, cfg_q, 8'h00} :
                           (next_read_q == 8'd4) ? {dpfc_pkg::CMD_RD_THERMAL, ts_spread1, ts_spread2, 8'h00} :
                           {dpfc_pkg::CMD_NOP, 24'h00_0000};
  wire [5:0]  crc_fb     = {5'h00, crc_q[5] ^ shift_q[0]};
  wire [5:0]  crc_step   = {crc_q[4:0], 1'b0} ^ (crc_fb[0] ? dpfc_pkg::CRC_POLY : 6'h00);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      dpfc_pkg::DPFC_IDLE:  if (sel_fall) state_d = dpfc_pkg::DPFC_SHIFT;
      dpfc_pkg::DPFC_SHIFT: if (sel_rise) state_d = dpfc_pkg::DPFC_CLOSE;
      dpfc_pkg::DPFC_CLOSE: state_d = dpfc_pkg::DPFC_IDLE;
      default:              state_d = dpfc_pkg::DPFC_IDLE;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      sck_prev_q  <= 1'b0;
      sel_prev_q  <= 1'b1;
      clr_prev_q  <= 1'b1;
      async_load_n_prev_q <= 1'b1;
      state_q     <= dpfc_pkg::DPFC_IDLE;
    end
    else
    begin
      sck_prev_q  <= sck_s;
      sel_prev_q  <= sel_s;
      clr_prev_q  <= clr_s;
      async_load_n_prev_q <= async_load_n_s;
      state_q     <= state_d;
    end
  end

  // Shifter and running frame check; the check covers every bit before the code, the first 26,
  // so it is advanced on each bit except the last six.
  always_ff @(posedge CLK)
  begin
    if (SRST || sel_fall)
    begin
      shift_q <= 32'h0000_0000;
      count_q <= '0;
      crc_q   <= 6'h00;
    end
    else if (sck_rise && !sel_s)
    begin
      shift_q <= {shift_q[30:0], sdi_s};
      count_q <= count_q + 1'b1;
      crc_q   <= crc_q;
    end
    else if (crc_pend_q)
    begin
      crc_q   <= (count_q <= dpfc_pkg::CNT_W'(dpfc_pkg::FRAME_W - dpfc_pkg::CRC_W)) ? crc_step : crc_q;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      crc_pend_q <= 1'b0;
    else
      crc_pend_q <= sck_rise && !sel_s;
  end

  // Register state; only resets, the clear pin, decoded writes, load-pin falls and fault or thermal events change it, so sleep leaves it intact.
  wire [7:0]  tsd_next   = wake_all ? thermal_hit : (tsd_q | thermal_hit);
  // Reset bit is never stored, so it reads back as zero.
  wire [2:0]  cfg_next   = soft_rst ? dpfc_pkg::CFG_RESET : (do_cfg ? byte2[2:0] : cfg_q);

  always_ff @(posedge CLK)
  begin
    if (SRST)
      pd_q <= dpfc_pkg::PWR_RESET;
    else
      pd_q <= pd_next;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      tsd_q <= 8'h00;
    else
      tsd_q <= tsd_next;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      fault_q <= dpfc_pkg::FAULT_RESET;
    else
      fault_q <= flt_base | flt_set;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      cfg_q <= dpfc_pkg::CFG_RESET;
    else
      cfg_q <= cfg_next;
  end

  // Fault pin: event pulls low, the next select rise releases unless a new event lands.
  always_ff @(posedge CLK)
  begin
    if (SRST)
      fault_pin_q <= 1'b0;
    else if (|flt_set)
      fault_pin_q <= 1'b1;
    else if (sel_rise)
      fault_pin_q <= 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      next_read_q     <= 8'd0;
      tx_q            <= 32'h0000_0000;
    end
    else
    begin
      if (sel_rise)
        next_read_q <= (valid ? read_sel : 8'd0);
      if (sel_fall)
        tx_q <= tx_load;
      else if (sck_fall && !sel_s)
        tx_q <= {tx_q[30:0], 1'b0};
    end
  end

  // Outputs, each from a flip-flop of its own.
  // Load all while idle, or at frame close when the load pin is still low.
  wire        load_idle  = async_load_n_low && sel_s && state_q == dpfc_pkg::DPFC_IDLE;
  wire        load_close = valid && async_load_n_low;
  wire [7:0]  load_next  = (load_idle || load_close) ? 8'hFF : upd_mask;
  wire        all_down   = (pd_q == 8'hFF);
  // Charging is pointless with an external reference or with the whole chip asleep.
  wire        charge_next = ~cfg_q[dpfc_pkg::CFG_EXT_POS] && !all_down;

  always_ff @(posedge CLK)
  begin
    if (SRST)
      SDO <= 1'b0;
    else
      SDO <= tx_q[31];
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      SDO_OE_N <= 1'b1;
    else
      SDO_OE_N <= sel_s;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      FAULT_O <= 1'b0;
    else
      FAULT_O <= 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      FAULT_OE_N <= 1'b1;
    else
      FAULT_OE_N <= ~fault_pin_q;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      CHAN_SLEEP_BIT <= dpfc_pkg::PWR_RESET;
    else
      CHAN_SLEEP_BIT <= pd_q;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      DEVICE_SLEEP <= 1'b0;
    else
      DEVICE_SLEEP <= all_down;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      DAC_LOAD <= 8'h00;
    else
      DAC_LOAD <= load_next;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      EXTERNAL_VREF_SELECT <= 1'b0;
    else
      EXTERNAL_VREF_SELECT <= cfg_q[dpfc_pkg::CFG_EXT_POS];
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      VREF_COMP_CHARGE_EN <= 1'b1;
    else
      VREF_COMP_CHARGE_EN <= charge_next;
  end
endmodule

// ### sim/dpfc_ctrl_assertions.sv
// Purpose: Port-level checks of the DAC power, fault and configuration control block.
// Assumes: All checks run on CLK; SRST disables them.
// Notes:   Pin-to-register lags of a few cycles are covered by short repetitions.
`timescale 1ns/1ns
module dpfc_ctrl_chk
(
  input wire logic       CLK,
  input wire logic       SRST,
  input wire logic       SELECT_LOAD_N,
  input wire logic       ASYNC_LOAD_N,
  input wire logic [7:0] CHAN_OVERTEMP,
  input wire logic       SDO_OE_N,
  input wire logic       FAULT_O,
  input wire logic       FAULT_OE_N,
  input wire logic [7:0] CHAN_SLEEP_BIT,
  input wire logic       DEVICE_SLEEP,
  input wire logic [7:0] DAC_LOAD,
  input wire logic       EXTERNAL_VREF_SELECT,
  input wire logic       VREF_COMP_CHARGE_EN
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);
  // Cycles since select was last high; it saturates so long frames stay cheap.
  logic [3:0] since_sel_q;
  logic [3:0] since_sel_d;
  assign since_sel_d = (SRST || SELECT_LOAD_N) ? 4'h0 : (&since_sel_q ? since_sel_q : since_sel_q + 4'h1);
  always_ff @(posedge CLK)
  begin
    since_sel_q <= since_sel_d;
  end
  sequence s_load_idle;
    (!ASYNC_LOAD_N && SELECT_LOAD_N)[*6];
  endsequence
  sequence s_load_in_frame;
    (!ASYNC_LOAD_N && !SELECT_LOAD_N)[*6];
  endsequence
  a_reset_state: assert property ($fell(SRST) |-> CHAN_SLEEP_BIT == 8'h00 && FAULT_OE_N && SDO_OE_N
    && DAC_LOAD == 8'h00 && VREF_COMP_CHARGE_EN) else $error("outputs not at reset values");
  a_sleep_all_down: assert property ($stable(CHAN_SLEEP_BIT)[*3] |-> DEVICE_SLEEP == &CHAN_SLEEP_BIT)
    else $error("device sleep does not follow power-down bits");
  a_pdn_frame_quiet: assert property (since_sel_q > 4'h6 && CHAN_OVERTEMP == 8'h00 && $past(CHAN_OVERTEMP) == 8'h00
    |-> (CHAN_SLEEP_BIT & ~$past(CHAN_SLEEP_BIT)) == 8'h00) else $error("channel powered down inside a frame");
  a_external_vref_select_charge: assert property (EXTERNAL_VREF_SELECT[*2] |-> !VREF_COMP_CHARGE_EN)
    else $error("charging current on in external reference mode");
  a_fault_cause: assert property ($fell(FAULT_OE_N) && (CHAN_OVERTEMP | $past(CHAN_OVERTEMP)
    | $past(CHAN_OVERTEMP, 2)) == 8'h00 |-> since_sel_q < 4'h8) else $error("fault pin pulled without a cause");
  a_sdo_released: assert property (SELECT_LOAD_N[*5] |-> SDO_OE_N)
    else $error("serial output driven between frames");
  a_load_idle_copy: assert property (s_load_idle |-> DAC_LOAD == 8'hFF)
    else $error("load pin low while idle did not load all channels");
  a_load_frame_hold: assert property (s_load_in_frame |-> DAC_LOAD == 8'h00)
    else $error("load pin low in a frame updated outputs");
  a_load_wakes: assert property ((!ASYNC_LOAD_N && CHAN_OVERTEMP == 8'h00)[*8] |-> CHAN_SLEEP_BIT == 8'h00)
    else $error("load pin low left channels powered down");
  a_fault_open_drain: assert property (FAULT_O == 1'b0)
    else $error("fault pin driven high");
endmodule
bind dpfc_ctrl dpfc_ctrl_chk chk_i
(
  .CLK(CLK), .SRST(SRST), .SELECT_LOAD_N(SELECT_LOAD_N), .ASYNC_LOAD_N(ASYNC_LOAD_N),
  .CHAN_OVERTEMP(CHAN_OVERTEMP), .SDO_OE_N(SDO_OE_N), .FAULT_O(FAULT_O), .FAULT_OE_N(FAULT_OE_N),
  .CHAN_SLEEP_BIT(CHAN_SLEEP_BIT), .DEVICE_SLEEP(DEVICE_SLEEP), .DAC_LOAD(DAC_LOAD),
  .EXTERNAL_VREF_SELECT(EXTERNAL_VREF_SELECT), .VREF_COMP_CHARGE_EN(VREF_COMP_CHARGE_EN)
);

// ### sim/dpfc_host.sv
// Purpose: Host serial controller model that sends command frames and captures readback.
// Assumes: Serial clock half period is four CLK cycles, changed on the falling CLK edge.
// Notes:   The serial clock rests low between frames; data is inverted after the last bit, before select rises.
`timescale 1ns/1ns
module dpfc_host
(
  input  wire logic CLK,
  input  wire logic SDO,
  output logic      SCK,
  output logic      SDI,
  output logic      SEL_N
);
  initial
  begin
    SCK = 1'b0;
    SDI = 1'b1;
    SEL_N = 1'b1;
  end
  task automatic half();
    repeat (4) @(negedge CLK);
  endtask
  // Sends the top n bits of w, MSB first; r gathers the device output at each rise.
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
    int k;
    r = '0;
    SEL_N = 1'b0;
    half();
    for (k = 0; k < n; k++)
    begin
      SDI = w[31-k];
      half();
      SCK = 1'b1;
      r = {r[30:0], SDO};
      half();
      SCK = 1'b0;
    end
    SDI = ~SDI;
    half();
    SEL_N = 1'b1;
    repeat (6) @(negedge CLK);
  endtask
endmodule

// ### sim/tb_dpfc_ctrl.sv
// Purpose: Self-checking bench for the DAC power, fault and configuration control block.
// Assumes: The host model frames all traffic; other pins change on the falling CLK edge.
// Notes:   Expected power readback words come from the bench's own bit spreading; frame check codes come from its CRC function.
`timescale 1ns/1ns
module tb_dpfc_ctrl;
  logic        clk, srst, sck, sdi, sel_n, ld_n, clr_n, sdo, sdo_oe_n, fault_o, fault_oe_n;
  logic        dev_sleep, ext, chg, sdo_w, fault_w;
  logic [7:0]  ot, sleep, p;
  logic [31:0] r;
  int          mismatches, cmp_count, i;
  // The serial output and the fault pin both have pull-ups on the board.
  assign sdo_w = sdo_oe_n ? 1'b1 : sdo;
  assign fault_w = fault_oe_n ? 1'b1 : fault_o;
  dpfc_host host (.CLK(clk), .SDO(sdo_w), .SCK(sck), .SDI(sdi), .SEL_N(sel_n));
  dpfc_ctrl DUT
  (
    .CLK(clk), .SRST(srst), .SCK(sck), .SDI(sdi), .SELECT_LOAD_N(sel_n), .ASYNC_LOAD_N(ld_n),
    .ASYNC_CLEAR_N(clr_n), .CHAN_OVERTEMP(ot), .SDO(sdo), .SDO_OE_N(sdo_oe_n), .FAULT_O(fault_o),
    .FAULT_OE_N(fault_oe_n), .CHAN_SLEEP_BIT(sleep), .DEVICE_SLEEP(dev_sleep), .DAC_LOAD(),
    .EXTERNAL_VREF_SELECT(ext), .VREF_COMP_CHARGE_EN(chg)
  );
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] spread(input logic [7:0] b);
    int k;
    spread = '0;
    for (k = 0; k < 8; k++)
      spread[2*k] = b[k];
  endfunction
  function automatic logic [5:0] crc6(input logic [25:0] d);
    int k;
    logic fb;
    crc6 = '0;
    for (k = 25; k >= 0; k--)
    begin
      fb = d[k] ^ crc6[5];
      crc6 = {crc6[4:0], 1'b0} ^ (fb ? dpfc_pkg::CRC_POLY : 6'h00);
    end
  endfunction
  // A set bad flag corrupts the check code so a checked frame is refused.
  task automatic frame(input logic [7:0] c, input logic [15:0] d, input int n, input logic bad);
    logic [31:0] w;
    w = {c, d, 8'h00};
    w[5:0] = crc6(w[31:6]) ^ {5'h00, bad};
    host.xfer(w, n, r);
    repeat (8) @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] c);
    frame(c, 16'h0000, 32, 1'b0);
    frame(dpfc_pkg::CMD_NOP, 16'h0000, 32, 1'b0);
  endtask
  task automatic stop_test();
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // The traffic needs about 13,000 cycles; the limit allows roughly twice that.
  initial
  begin
    #1500000;
    mismatches++;
    stop_test();
  end
  initial
  begin
    srst = 1'b1;
    ld_n = 1'b1;
    clr_n = 1'b1;
    ot = 8'h00;
    mismatches = 0;
    cmp_count = 0;
    void'($urandom(75));
    repeat (20) @(negedge clk);
    srst = 1'b0;
    repeat (6) @(negedge clk);
    chk(32'({sleep, ext, chg, fault_w}), 32'({8'h00, 3'b011}));
    for (i = 0; i < 6; i++)
    begin
      p = (i == 0) ? 8'hFF : 8'($urandom);
      frame(dpfc_pkg::CMD_WR_POWER, spread(p), (i == 1) ? 24 : 32, 1'b0);
      chk(32'(sleep), 32'(p));
      chk(32'(dev_sleep), 32'(&p));
      rd(dpfc_pkg::CMD_RD_POWER);
      chk(32'(r[31:8]), 32'({dpfc_pkg::CMD_RD_POWER, spread(p)}));
      chk(32'(sleep), 32'(p));
    end
    frame(dpfc_pkg::CMD_WR_POWER, spread(8'hFF), 32, 1'b0);
    p = 8'($urandom % 8);
    frame({dpfc_pkg::CMD_UPDATE_HI, 1'b0, p[2:0]}, 16'h1234, 32, 1'b0);
    repeat (1000) @(negedge clk);
    chk(32'({sleep, dev_sleep}), 32'({8'hFF & ~(8'h01 << p), 1'b0}));
    ld_n = 1'b0;
    repeat (10) @(negedge clk);
    frame(dpfc_pkg::CMD_WR_POWER, spread(8'hFF), 32, 1'b0);
    chk(32'(sleep), 32'h0000_0000);
    ld_n = 1'b1;
    frame(dpfc_pkg::CMD_NOP, 16'h0000, 25, 1'b0);
    chk(32'(fault_w), 32'h0000_0000);
    rd(dpfc_pkg::CMD_RD_FAULT);
    chk(32'(r[31:8]), 32'({dpfc_pkg::CMD_RD_FAULT, 16'h0002}));
    chk(32'(fault_w), 32'h0000_0001);
    frame(dpfc_pkg::CMD_WR_FAULT, 16'h0000, 24, 1'b0);
    rd(dpfc_pkg::CMD_RD_FAULT);
    chk(32'(r[31:8]), 32'({dpfc_pkg::CMD_RD_FAULT, 16'h0000}));
    frame(dpfc_pkg::CMD_WR_CONFIG, 16'h0003, 32, 1'b0);
    chk(32'({ext, chg}), 32'h0000_0002);
    frame(dpfc_pkg::CMD_WR_POWER, spread(8'h0F), 32, 1'b1);
    chk(32'({sleep, fault_w}), 32'h0000_0000);
    rd(dpfc_pkg::CMD_RD_FAULT);
    chk(32'(r[31:8]), 32'({dpfc_pkg::CMD_RD_FAULT, 16'h0001}));
    frame(dpfc_pkg::CMD_WR_FAULT, 16'h0000, 32, 1'b1);
    rd(dpfc_pkg::CMD_RD_FAULT);
    chk(32'(r[31:8]), 32'({dpfc_pkg::CMD_RD_FAULT, 16'h0000}));
    frame(dpfc_pkg::CMD_WR_POWER, spread(8'h0F), 32, 1'b0);
    chk(32'(sleep), 32'h0000_000F);
    frame(dpfc_pkg::CMD_WR_CONFIG, 16'h8000, 32, 1'b0);
    chk(32'({sleep, ext, chg}), 32'h0000_0001);
    rd(dpfc_pkg::CMD_RD_CONFIG);
    chk(32'(r[31:8]), 32'({dpfc_pkg::CMD_RD_CONFIG, 16'h0000}));
    ot = 8'h04;
    repeat (4) @(negedge clk);
    ot = 8'h00;
    repeat (4) @(negedge clk);
    chk(32'({sleep, fault_w}), 32'h0000_0008);
    rd(dpfc_pkg::CMD_RD_FAULT);
    chk(32'(r[31:8]), 32'({dpfc_pkg::CMD_RD_FAULT, 16'h0004}));
    clr_n = 1'b0;
    repeat (4) @(negedge clk);
    clr_n = 1'b1;
    repeat (8) @(negedge clk);
    chk(32'(sleep), 32'h0000_0000);
    rd(dpfc_pkg::CMD_RD_FAULT);
    chk(32'(r[31:8]), 32'({dpfc_pkg::CMD_RD_FAULT, 16'h0000}));
    frame(dpfc_pkg::CMD_WR_CONFIG, 16'h0004, 32, 1'b0);
    ot = 8'h10;
    repeat (4) @(negedge clk);
    ot = 8'h00;
    repeat (4) @(negedge clk);
    chk(32'({sleep, fault_w}), 32'h0000_0001);
    stop_test();
  end
endmodule
